/* File: src/cies_pkg.sv */
// Package for the instruction execution slice: opcodes and reset values.
// Assumes 10-bit instruction words presented one per machine cycle.
package cies_pkg;
  localparam int OP_W = 10;
  localparam int NIB_W = 4;
  // Instruction codes of the four handled instructions.
  localparam logic [OP_W-1:0] OPC_ACC_INVERT = 10'h01C;
  localparam logic [OP_W-1:0] OPC_RC_CLOCK_SELECT = 10'h29B;
  localparam logic [OP_W-1:0] OPC_POINTER_DECREMENT = 10'h017;
  localparam logic [OP_W-1:0] OPC_IRQ_DISABLE = 10'h004;
  // Pointer value that causes a skip after a decrement.
  localparam logic [NIB_W-1:0] PTR_SKIP_VALUE = 4'hF;
  localparam logic [NIB_W-1:0] PTR_STEP = 4'h1;
  // Reset values.
  localparam logic [NIB_W-1:0] ACC_RESET = 4'h0;
  localparam logic [NIB_W-1:0] PTR_RESET = 4'h0;
  localparam logic IRQ_EN_RESET = 1'b0;
  localparam logic RC_SEL_RESET = 1'b0;
  // Decoded operation kinds.
  typedef enum logic [2:0] {
    CIES_OP_NONE,
    CIES_OP_ACC_INVERT,
    CIES_OP_RC_CLOCK_SELECT,
    CIES_OP_POINTER_DECREMENT,
    CIES_OP_IRQ_DISABLE
  } cies_op_t;
endpackage

/* File: src/cies_exec_slice.sv */
// Execution slice for four instructions of a 4-bit CPU.
// Assumes the fetch stage presents one opcode with a valid strobe per
// machine cycle, all on clk; other units write the shared state via ports.
// Load ports from the rest of the CPU lose to an opcode for the same register in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cies_exec_slice
  import cies_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Opcode from the fetch stage.
  input wire logic op_valid,
  input wire logic [OP_W-1:0] op_code,
  // Writes from the rest of the CPU.
  input wire logic acc_load,
  input wire logic [NIB_W-1:0] acc_load_data,
  input wire logic ptr_load,
  input wire logic [NIB_W-1:0] ptr_load_data,
  input wire logic irq_enable_set,
  input wire logic carry_in,
  // State towards the rest of the CPU.
  output logic [NIB_W-1:0] acc_out,
  output logic [NIB_W-1:0] ptr_out,
  output logic carry_out,
  output logic skip_next,
  output logic irq_enable,
  output logic rc_clock_sel
);

  logic [NIB_W-1:0] acc_reg;
  logic [NIB_W-1:0] ptr_reg;
  logic [NIB_W-1:0] ptr_next;
  logic skip_reg;
  logic irq_en_reg;
  logic irq_clr_pend_reg;
  logic rc_sel_reg;
  cies_op_t op_kind;

  // Maps an opcode to the operation kind it requests.
  function automatic cies_op_t decode_op(input logic [OP_W-1:0] code);
    cies_op_t k;
    k = CIES_OP_NONE;
    unique case (code)
      OPC_ACC_INVERT: k = CIES_OP_ACC_INVERT;
      OPC_RC_CLOCK_SELECT: k = CIES_OP_RC_CLOCK_SELECT;
      OPC_POINTER_DECREMENT: k = CIES_OP_POINTER_DECREMENT;
      OPC_IRQ_DISABLE: k = CIES_OP_IRQ_DISABLE;
      default: k = CIES_OP_NONE;
    endcase
    return k;
  endfunction

  // Decode only when the fetch stage offers an opcode.
  always_comb begin
    op_kind = op_valid ? decode_op(op_code) : CIES_OP_NONE;
  end

  // Wrapping 4-bit subtract; all-ones follows zero naturally.
  assign ptr_next = ptr_reg - PTR_STEP;

  // Accumulator: complement replaces every bit, carry passes untouched.
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= ACC_RESET;
    end else if (op_kind == CIES_OP_ACC_INVERT) begin
      acc_reg <= ~acc_reg;
    end else if (acc_load) begin
      acc_reg <= acc_load_data;
    end
  end

  // An invert must complement all four bits and leave no skip behind.
  a_acc_invert: assert property (
    @(posedge clk) disable iff (rst)
    op_kind == CIES_OP_ACC_INVERT |=>
      (acc_out == ~$past(acc_out)) && !skip_next)
    else $error("Accumulator not complemented or skip raised.");

  // A load with no invert in the way must land unchanged.
  a_acc_load: assert property (
    @(posedge clk) disable iff (rst)
    acc_load && op_kind != CIES_OP_ACC_INVERT |=>
      acc_out == $past(acc_load_data))
    else $error("Accumulator load did not land.");

  // Column pointer register.
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= PTR_RESET;
    end else if (op_kind == CIES_OP_POINTER_DECREMENT) begin
      ptr_reg <= ptr_next;
    end else if (ptr_load) begin
      ptr_reg <= ptr_load_data;
    end
  end

  // A decrement must take exactly one off, wrapping below zero.
  a_ptr_decrement: assert property (
    @(posedge clk) disable iff (rst)
    op_kind == CIES_OP_POINTER_DECREMENT |=>
      ptr_out == $past(ptr_out) - PTR_STEP)
    else $error("Pointer did not decrement by one.");

  // A load with no decrement in the way must land unchanged.
  a_ptr_load: assert property (
    @(posedge clk) disable iff (rst)
    ptr_load && op_kind != CIES_OP_POINTER_DECREMENT |=>
      ptr_out == $past(ptr_load_data))
    else $error("Pointer load did not land.");

  // Skip flag for the instruction after this one; only decrement sets it.
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else if (op_valid) begin
      skip_reg <= (op_kind == CIES_OP_POINTER_DECREMENT) &&
                  (ptr_next == PTR_SKIP_VALUE);
    end
  end

  // The skip follows the pointer value that the decrement produced.
  a_skip_on_fifteen: assert property (
    @(posedge clk) disable iff (rst)
    op_kind == CIES_OP_POINTER_DECREMENT |=>
      skip_next == (ptr_out == PTR_SKIP_VALUE))
    else $error("Skip does not match decremented pointer.");

  // Any other taken opcode, unknown ones included, clears the skip.
  a_skip_clear: assert property (
    @(posedge clk) disable iff (rst)
    op_valid && op_kind != CIES_OP_POINTER_DECREMENT |=> !skip_next)
    else $error("Skip raised by an opcode other than a decrement.");

  // Interrupt enable: the clear is held pending for one machine cycle,
  // so the flag still reads high in the cycle after the disable.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_clr_pend_reg <= 1'b0;
    end else begin
      irq_clr_pend_reg <= (op_kind == CIES_OP_IRQ_DISABLE);
    end
  end

  // The flag drops one cycle after the disable; a new enable wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_reg <= IRQ_EN_RESET;
    end else if (irq_enable_set) begin
      irq_en_reg <= 1'b1;
    end else if (irq_clr_pend_reg) begin
      irq_en_reg <= 1'b0;
    end
  end

  // Two quiet cycles after a disable the flag must be down.
  a_irq_clear: assert property (
    @(posedge clk) disable iff (rst)
    (op_kind == CIES_OP_IRQ_DISABLE && !irq_enable_set) ##1
      !irq_enable_set |=> !irq_enable)
    else $error("Interrupt enable not cleared after disable.");

  // The flag must not move in the cycle right after the disable; only an
  // enable pulse or a disable one cycle earlier may move it there.
  a_irq_delay: assert property (
    @(posedge clk) disable iff (rst)
    op_kind == CIES_OP_IRQ_DISABLE |=>
      (irq_enable == $past(irq_enable)) || $past(irq_enable_set) ||
      $past(irq_clr_pend_reg))
    else $error("Interrupt enable cleared too early.");

  // An enable pulse from elsewhere beats a pending clear.
  a_irq_set_wins: assert property (
    @(posedge clk) disable iff (rst)
    irq_enable_set |=> irq_enable)
    else $error("Interrupt enable not set by the enable pulse.");

  // Main clock source selection; stays on RC once chosen.
  always_ff @(posedge clk) begin
    if (rst) begin
      rc_sel_reg <= RC_SEL_RESET;
    end else if (op_kind == CIES_OP_RC_CLOCK_SELECT) begin
      rc_sel_reg <= 1'b1;
    end
  end

  // The RC choice appears right after the select instruction.
  a_rc_select: assert property (
    @(posedge clk) disable iff (rst)
    op_kind == CIES_OP_RC_CLOCK_SELECT |=> rc_clock_sel [*2])
    else $error("RC clock not selected.");

  // Once chosen, only a reset may hand the main clock back.
  a_rc_sticky: assert property (
    @(posedge clk) disable iff (rst)
    rc_clock_sel |=> rc_clock_sel)
    else $error("RC clock selection dropped without reset.");

  // Outputs come straight from registers; carry is passed through.
  assign acc_out = acc_reg;
  assign ptr_out = ptr_reg;
  assign carry_out = carry_in;
  assign skip_next = skip_reg;
  assign irq_enable = irq_en_reg;
  assign rc_clock_sel = rc_sel_reg;

  // Main scenarios that the opcode sequences are expected to reach.
  c_decrement_skip: cover property (@(posedge clk) disable iff (rst)
    op_kind == CIES_OP_POINTER_DECREMENT ##1 skip_next);
  c_disable_effect: cover property (@(posedge clk) disable iff (rst)
    irq_enable && op_kind == CIES_OP_IRQ_DISABLE ##2 !irq_enable);
  c_invert: cover property (@(posedge clk) disable iff (rst)
    op_kind == CIES_OP_ACC_INVERT);
  c_rc_select: cover property (@(posedge clk) disable iff (rst)
    !rc_clock_sel && op_kind == CIES_OP_RC_CLOCK_SELECT ##1 rc_clock_sel);
  c_unknown_op: cover property (@(posedge clk) disable iff (rst)
    op_valid && op_kind == CIES_OP_NONE);

endmodule
`default_nettype wire

/* File: verif/cies_fetch_model.sv */
// Fetch-stage model: presents each opcode for one machine cycle, then at least one idle cycle.
// Assumes the bench calls issue from its main sequence on clk.
`timescale 1ns/1ps
`default_nettype none
module cies_fetch_model
  import cies_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Opcode towards the slice.
  output logic op_valid,
  output logic [OP_W-1:0] op_code
);
  // Idle bus starts with a pattern no opcode uses.
  initial begin
    op_valid = 1'b0;
    op_code = 10'h3FF;
  end
  // Holds one opcode for a taking edge, then inverts the idle bus.
  task automatic issue(input logic [OP_W-1:0] code);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= code;
    @(posedge clk);
    op_valid <= 1'b0;
    op_code <= ~code;
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Bench for the execution slice: opcode sequences with expected state.
// Assumes the fetch model drives the opcode port on rising edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cies_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic acc_load = 1'b0, ptr_load = 1'b0, irq_enable_set = 1'b0;
  logic carry_in = 1'b1;
  logic [NIB_W-1:0] acc_load_data = 4'h5, ptr_load_data = 4'h0;
  logic op_valid, carry_out, skip_next, irq_enable, rc_clock_sel;
  logic [OP_W-1:0] op_code;
  logic [NIB_W-1:0] acc_out, ptr_out;
  int err_count = 0;
  int n_checks = 0;
  // An opcode that the slice does not handle.
  localparam logic [OP_W-1:0] OPC_UNUSED = 10'h3FF;
  // Machine-cycle clock of 100 ns.
  always #50 clk = ~clk;
  cies_fetch_model fm_i (.clk, .op_valid, .op_code);
  cies_exec_slice cies_exec_slice_i (.clk, .rst, .op_valid, .op_code,
    .acc_load, .acc_load_data, .ptr_load, .ptr_load_data,
    .irq_enable_set, .carry_in, .acc_out, .ptr_out, .carry_out,
    .skip_next, .irq_enable, .rc_clock_sel);
  // Compares one nibble-wide result.
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Issues one opcode and lets the taking edge settle.
  task automatic run(input logic [OP_W-1:0] code);
    fm_i.issue(code);
    #1;
  endtask
  // Main sequence of tests.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    run(OPC_POINTER_DECREMENT);
    chk(ptr_out, 4'hF);
    chk({3'b0, skip_next}, 4'h1);
    run(OPC_UNUSED);
    chk(ptr_out, 4'hF);
    chk({3'h0, skip_next}, 4'h0);
    run(OPC_POINTER_DECREMENT);
    chk(ptr_out, 4'hE);
    chk({3'b0, skip_next}, 4'h0);
    $display("test decrement done");
    @(posedge clk);
    {acc_load, ptr_load} <= 2'b11;
    @(posedge clk);
    {acc_load, ptr_load} <= 2'b00;
    run(OPC_POINTER_DECREMENT);
    chk(ptr_out, 4'hF);
    chk({3'h0, skip_next}, 4'h1);
    run(OPC_ACC_INVERT);
    chk(acc_out, 4'hA);
    chk({3'b0, skip_next}, 4'h0);
    chk({3'b0, carry_out}, 4'h1);
    @(posedge clk);
    carry_in <= 1'b0;
    #1;
    chk({3'h0, carry_out}, 4'h0);
    $display("test invert done");
    chk({3'b0, rc_clock_sel}, 4'h0);
    run(OPC_RC_CLOCK_SELECT);
    chk({3'b0, rc_clock_sel}, 4'h1);
    $display("test clock select done");
    @(posedge clk);
    irq_enable_set <= 1'b1;
    @(posedge clk);
    irq_enable_set <= 1'b0;
    run(OPC_IRQ_DISABLE);
    chk({3'b0, irq_enable}, 4'h1);
    @(posedge clk);
    #1;
    chk({3'b0, irq_enable}, 4'h0);
    $display("test interrupt disable done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({3'h0, rc_clock_sel}, 4'h0);
    run(OPC_POINTER_DECREMENT);
    chk(ptr_out, 4'hF);
    chk({3'h0, skip_next}, 4'h1);
    $display("test reset done");
    results();
  end
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
